// File: verilog/pss_pkg.sv
// Constants and types shared by the serial register slave
package pss_pkg;
	// Widths
	localparam int PSS_DATA_W = 8;
	localparam int PSS_ADDR_W = 7;
	localparam int PSS_CNT_W  = 4;

	// Fixed slave address
	localparam logic [PSS_ADDR_W-1:0] PSS_SLAVE_ADDR = 7'h7e;

	// Bit counter: bits received so far, then the acknowledge slot
	localparam logic [PSS_CNT_W-1:0] PSS_CNT_ZERO = 4'h0;
	localparam logic [PSS_CNT_W-1:0] PSS_CNT_BYTE = 4'h8;
	localparam logic [PSS_CNT_W-1:0] PSS_CNT_ACK  = 4'h9;

	// Values after reset, and the pointer step
	localparam logic [PSS_DATA_W-1:0] PSS_PTR_RST  = 8'h00;
	localparam logic [PSS_DATA_W-1:0] PSS_DATA_RST = 8'h00;
	localparam logic [PSS_DATA_W-1:0] PSS_PTR_STEP = 8'h01;
	localparam logic                  PSS_LINE_RST = 1'b1;

	// Transaction phase
	typedef enum logic [2:0] {
		PSS_IDLE,
		PSS_ADDR,
		PSS_REG,
		PSS_WDATA,
		PSS_RDATA,
		PSS_IGNORE
	} pss_state_t;
endpackage

// File: verilog/pss_serial_slave.sv
// Two-wire serial slave giving a host access to 8-bit device registers
`timescale 1ns/1ps
module pss_serial_slave #(
	parameter logic [pss_pkg::PSS_ADDR_W-1:0] SLAVE_ADDR =
		pss_pkg::PSS_SLAVE_ADDR
) (
	// System side
	input  wire logic                            clk_i,
	input  wire logic                            rst_i,
	// Link side, on the link clock
	input  wire logic                            link_clk_i,
	input  wire logic                            scl_i,
	input  wire logic                            sda_i,
	output logic                                 sda_o,
	output logic                                 sda_oe_n_o,
	// Register write port
	output logic                                 wr_valid_o,
	output logic [pss_pkg::PSS_DATA_W-1:0]       wr_addr_o,
	output logic [pss_pkg::PSS_DATA_W-1:0]       wr_data_o,
	// Register read port
	output logic [pss_pkg::PSS_DATA_W-1:0]       rd_addr_o,
	input  wire logic [pss_pkg::PSS_DATA_W-1:0]  rd_data_i,
	// Status
	output logic                                 bus_busy_o
);
	import pss_pkg::*;

	// Link domain reset, taken from the system reset
	logic lrst_meta_r;
	logic lrst_r;

	always_ff @(posedge link_clk_i) begin
		lrst_meta_r <= rst_i;
		lrst_r      <= lrst_meta_r;
	end

	// Line synchronisers plus one stage for edge detection
	logic scl_meta_r, scl_s_r, scl_d_r;
	logic sda_meta_r, sda_s_r, sda_d_r;

	always_ff @(posedge link_clk_i) begin
		if (lrst_r) begin
			scl_meta_r <= PSS_LINE_RST;
			scl_s_r    <= PSS_LINE_RST;
			scl_d_r    <= PSS_LINE_RST;
			sda_meta_r <= PSS_LINE_RST;
			sda_s_r    <= PSS_LINE_RST;
			sda_d_r    <= PSS_LINE_RST;
		end else begin
			scl_meta_r <= scl_i;
			scl_s_r    <= scl_meta_r;
			scl_d_r    <= scl_s_r;
			sda_meta_r <= sda_i;
			sda_s_r    <= sda_meta_r;
			sda_d_r    <= sda_s_r;
		end
	end

	// Line events
	wire scl_rise  = scl_s_r & ~scl_d_r;
	wire scl_fall  = ~scl_s_r & scl_d_r;
	wire scl_high  = scl_s_r & scl_d_r;
	wire start_det = scl_high & sda_d_r & ~sda_s_r;
	wire stop_det  = scl_high & ~sda_d_r & sda_s_r;

	// Link engine state
	pss_state_t               state_r, state_nxt;
	logic [PSS_CNT_W-1:0]     cnt_r, cnt_nxt;
	logic [PSS_DATA_W-1:0]    rx_sh_r, rx_sh_nxt;
	logic [PSS_DATA_W-1:0]    tx_sh_r, tx_sh_nxt;
	logic [PSS_DATA_W-1:0]    ptr_r, ptr_nxt;
	logic [PSS_DATA_W-1:0]    fetch_addr_r, fetch_addr_nxt;
	logic [PSS_DATA_W-1:0]    fetch_data_r;
	logic [PSS_DATA_W-1:0]    wr_addr_lk_r, wr_addr_lk_nxt;
	logic [PSS_DATA_W-1:0]    wr_data_lk_r, wr_data_lk_nxt;
	logic                     wr_tgl_r, wr_tgl_nxt;
	logic                     rd_req_tgl_r, rd_req_tgl_nxt;
	logic                     oe_n_r, oe_n_nxt;
	logic                     dir_rd_r, dir_rd_nxt;
	logic                     mack_r, mack_nxt;
	logic                     busy_r, busy_nxt;
	logic                     sda_low_r;

	// Decoding
	wire addr_match = rx_sh_r[PSS_DATA_W-1:1] == SLAVE_ADDR;
	wire bit_rise   = scl_rise & (cnt_r < PSS_CNT_BYTE);
	wire byte_fall  = scl_fall & (cnt_r == PSS_CNT_BYTE);
	wire ack_rise   = scl_rise & (cnt_r == PSS_CNT_ACK);
	wire ack_fall   = scl_fall & (cnt_r == PSS_CNT_ACK);
	wire tx_fall    = scl_fall & (cnt_r != PSS_CNT_ZERO)
		& (cnt_r < PSS_CNT_BYTE) & (state_r == PSS_RDATA);
	wire [PSS_DATA_W-1:0] ptr_inc = PSS_DATA_W'(ptr_r + PSS_PTR_STEP);
	wire [PSS_DATA_W-1:0] ptr_inc2 = PSS_DATA_W'(ptr_inc + PSS_PTR_STEP);

	always_comb begin
		state_nxt      = state_r;
		cnt_nxt        = cnt_r;
		rx_sh_nxt      = rx_sh_r;
		tx_sh_nxt      = tx_sh_r;
		ptr_nxt        = ptr_r;
		fetch_addr_nxt = fetch_addr_r;
		wr_addr_lk_nxt = wr_addr_lk_r;
		wr_data_lk_nxt = wr_data_lk_r;
		wr_tgl_nxt     = wr_tgl_r;
		rd_req_tgl_nxt = rd_req_tgl_r;
		oe_n_nxt       = oe_n_r;
		dir_rd_nxt     = dir_rd_r;
		mack_nxt       = mack_r;
		busy_nxt       = busy_r;
		if (start_det) begin
			// Fresh or repeated start: address phase again
			state_nxt = PSS_ADDR;
			cnt_nxt   = PSS_CNT_ZERO;
			oe_n_nxt  = 1'b1;
			busy_nxt  = 1'b1;
		end else if (stop_det) begin
			state_nxt = PSS_IDLE;
			cnt_nxt   = PSS_CNT_ZERO;
			oe_n_nxt  = 1'b1;
			busy_nxt  = 1'b0;
		end else if (state_r == PSS_IDLE || state_r == PSS_IGNORE) begin
			oe_n_nxt = 1'b1;
		end else if (bit_rise) begin
			// Sample while the clock is high, MSB first
			rx_sh_nxt = {rx_sh_r[PSS_DATA_W-2:0], sda_s_r};
			cnt_nxt   = PSS_CNT_W'(cnt_r + 4'h1);
		end else if (ack_rise) begin
			mack_nxt = ~sda_s_r;
		end else if (tx_fall) begin
			// Next bit goes out while the clock is low
			oe_n_nxt  = tx_sh_r[PSS_DATA_W-2];
			tx_sh_nxt = {tx_sh_r[PSS_DATA_W-2:0], 1'b1};
		end else if (byte_fall) begin
			cnt_nxt = PSS_CNT_ACK;
			case (state_r)
				PSS_ADDR: begin
					if (addr_match) begin
						oe_n_nxt   = 1'b0;
						dir_rd_nxt = rx_sh_r[0];
					end else begin
						state_nxt = PSS_IGNORE;
					end
				end
				PSS_REG: begin
					ptr_nxt        = rx_sh_r;
					fetch_addr_nxt = rx_sh_r;
					rd_req_tgl_nxt = ~rd_req_tgl_r;
					oe_n_nxt       = 1'b0;
				end
				PSS_WDATA: begin
					wr_addr_lk_nxt = ptr_r;
					wr_data_lk_nxt = rx_sh_r;
					wr_tgl_nxt     = ~wr_tgl_r;
					oe_n_nxt       = 1'b0;
				end
				PSS_RDATA: oe_n_nxt = 1'b1;
				default: oe_n_nxt = 1'b1;
			endcase
		end else if (ack_fall) begin
			cnt_nxt  = PSS_CNT_ZERO;
			oe_n_nxt = 1'b1;
			case (state_r)
				PSS_ADDR: begin
					if (dir_rd_r) begin
						// Transmit the pointed byte, prefetch the next
						state_nxt      = PSS_RDATA;
						tx_sh_nxt      = fetch_data_r;
						oe_n_nxt       = fetch_data_r[PSS_DATA_W-1];
						fetch_addr_nxt = ptr_inc;
						rd_req_tgl_nxt = ~rd_req_tgl_r;
					end else begin
						state_nxt = PSS_REG;
					end
				end
				PSS_REG: state_nxt = PSS_WDATA;
				PSS_WDATA: begin
					ptr_nxt        = ptr_inc;
					fetch_addr_nxt = ptr_inc;
					rd_req_tgl_nxt = ~rd_req_tgl_r;
				end
				PSS_RDATA: begin
					if (mack_r) begin
						ptr_nxt        = ptr_inc;
						tx_sh_nxt      = fetch_data_r;
						oe_n_nxt       = fetch_data_r[PSS_DATA_W-1];
						fetch_addr_nxt = ptr_inc2;
						rd_req_tgl_nxt = ~rd_req_tgl_r;
					end else begin
						state_nxt = PSS_IGNORE;
					end
				end
				default: state_nxt = PSS_IDLE;
			endcase
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst_r) begin
			state_r      <= PSS_IDLE;
			cnt_r        <= PSS_CNT_ZERO;
			rx_sh_r      <= PSS_DATA_RST;
			tx_sh_r      <= PSS_DATA_RST;
			ptr_r        <= PSS_PTR_RST;
			fetch_addr_r <= PSS_PTR_RST;
			wr_addr_lk_r <= PSS_PTR_RST;
			wr_data_lk_r <= PSS_DATA_RST;
			wr_tgl_r     <= 1'b0;
			rd_req_tgl_r <= 1'b0;
			oe_n_r       <= 1'b1;
			dir_rd_r     <= 1'b0;
			mack_r       <= 1'b0;
			busy_r       <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			cnt_r        <= cnt_nxt;
			rx_sh_r      <= rx_sh_nxt;
			tx_sh_r      <= tx_sh_nxt;
			ptr_r        <= ptr_nxt;
			fetch_addr_r <= fetch_addr_nxt;
			wr_addr_lk_r <= wr_addr_lk_nxt;
			wr_data_lk_r <= wr_data_lk_nxt;
			wr_tgl_r     <= wr_tgl_nxt;
			rd_req_tgl_r <= rd_req_tgl_nxt;
			oe_n_r       <= oe_n_nxt;
			dir_rd_r     <= dir_rd_nxt;
			mack_r       <= mack_nxt;
			busy_r       <= busy_nxt;
		end
	end

	// Output level is a constant low; only the enable moves
	always_ff @(posedge link_clk_i) begin
		sda_low_r <= 1'b0;
	end

	assign sda_o      = sda_low_r;
	assign sda_oe_n_o = oe_n_r;

	// Read answers come back as a toggle; the data word is held stable
	logic rd_ack_meta_r, rd_ack_s_r, rd_ack_d_r;
	logic rd_ack_tgl_r;
	logic [PSS_DATA_W-1:0] rd_data_r;

	always_ff @(posedge link_clk_i) begin
		if (lrst_r) begin
			rd_ack_meta_r <= 1'b0;
			rd_ack_s_r    <= 1'b0;
			rd_ack_d_r    <= 1'b0;
			fetch_data_r  <= PSS_DATA_RST;
		end else begin
			rd_ack_meta_r <= rd_ack_tgl_r;
			rd_ack_s_r    <= rd_ack_meta_r;
			rd_ack_d_r    <= rd_ack_s_r;
			if (rd_ack_s_r ^ rd_ack_d_r)
				fetch_data_r <= rd_data_r;
		end
	end

	// System domain: toggle synchronisers for write and fetch requests
	logic wr_meta_r, wr_s_r, wr_d_r;
	logic rq_meta_r, rq_s_r, rq_d_r;
	logic rd_pend_r;
	logic busy_meta_r, busy_s_r;
	logic wr_valid_r;
	logic [PSS_DATA_W-1:0] wr_addr_r, wr_data_r, rd_addr_r;

	wire wr_edge = wr_s_r ^ wr_d_r;
	wire rq_edge = rq_s_r ^ rq_d_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_meta_r   <= 1'b0;
			wr_s_r      <= 1'b0;
			wr_d_r      <= 1'b0;
			rq_meta_r   <= 1'b0;
			rq_s_r      <= 1'b0;
			rq_d_r      <= 1'b0;
			busy_meta_r <= 1'b0;
			busy_s_r    <= 1'b0;
		end else begin
			wr_meta_r   <= wr_tgl_r;
			wr_s_r      <= wr_meta_r;
			wr_d_r      <= wr_s_r;
			rq_meta_r   <= rd_req_tgl_r;
			rq_s_r      <= rq_meta_r;
			rq_d_r      <= rq_s_r;
			busy_meta_r <= busy_r;
			busy_s_r    <= busy_meta_r;
		end
	end

	// Address and data words are stable long before their toggle lands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_valid_r   <= 1'b0;
			wr_addr_r    <= PSS_PTR_RST;
			wr_data_r    <= PSS_DATA_RST;
			rd_addr_r    <= PSS_PTR_RST;
			rd_pend_r    <= 1'b0;
			rd_data_r    <= PSS_DATA_RST;
			rd_ack_tgl_r <= 1'b0;
		end else begin
			wr_valid_r <= wr_edge;
			rd_pend_r  <= rq_edge;
			if (wr_edge) begin
				wr_addr_r <= wr_addr_lk_r;
				wr_data_r <= wr_data_lk_r;
			end
			if (rq_edge)
				rd_addr_r <= fetch_addr_r;
			if (rd_pend_r) begin
				rd_data_r    <= rd_data_i;
				rd_ack_tgl_r <= ~rd_ack_tgl_r;
			end
		end
	end

	assign wr_valid_o = wr_valid_r;
	assign wr_addr_o  = wr_addr_r;
	assign wr_data_o  = wr_data_r;
	assign rd_addr_o  = rd_addr_r;
	assign bus_busy_o = busy_s_r;

	// Checks on the link engine
	default clocking lk_cb @(posedge link_clk_i);
	endclocking
	default disable iff (lrst_r);

	sequence addr_hit_s;
		byte_fall && !start_det && !stop_det && state_r == PSS_ADDR
			&& addr_match;
	endsequence

	sequence wdata_ack_end_s;
		ack_fall && !start_det && !stop_det && state_r == PSS_WDATA;
	endsequence

	// Only a matching address survives to the end of its slot in this phase
	sequence addr_end_s;
		ack_fall && !start_det && !stop_det && state_r == PSS_ADDR;
	endsequence

	chk_line_low_only: assert property (!oe_n_r |->
		sda_low_r == 1'b0)
		else $error("data line output not low");
	chk_start_busy: assert property (start_det |=> busy_r
		&& state_r == PSS_ADDR && cnt_r == PSS_CNT_ZERO)
		else $error("start not taken");
	chk_stop_idle: assert property (stop_det |=>
		state_r == PSS_IDLE && !busy_r && oe_n_r)
		else $error("stop did not return to idle");
	chk_addr_ack: assert property (addr_hit_s |=> !oe_n_r)
		else $error("matching address not acknowledged");
	chk_miss_silent: assert property (state_r == PSS_IGNORE
		|=> oe_n_r)
		else $error("ignored transaction drives line");
	chk_dir_latch: assert property (addr_hit_s |=>
		dir_rd_r == $past(rx_sh_r[0]))
		else $error("direction bit not latched");
	chk_read_dir: assert property (addr_end_s ##0 dir_rd_r
		|=> state_r == PSS_RDATA)
		else $error("read direction not entered");
	chk_write_dir: assert property (addr_end_s ##0 !dir_rd_r
		|=> state_r == PSS_REG)
		else $error("write direction not entered");
	chk_wr_step: assert property (wdata_ack_end_s |=>
		ptr_r == PSS_DATA_W'($past(ptr_r) + PSS_PTR_STEP))
		else $error("write pointer not advanced");
	chk_rd_step: assert property (ack_fall && !start_det
		&& !stop_det && state_r == PSS_RDATA && mack_r |=>
		ptr_r == PSS_DATA_W'($past(ptr_r) + PSS_PTR_STEP)
		&& oe_n_r == $past(fetch_data_r[PSS_DATA_W-1]))
		else $error("read pointer not advanced");
	chk_rd_release: assert property (state_r == PSS_RDATA
		&& cnt_r == PSS_CNT_ACK |-> oe_n_r)
		else $error("line held in master acknowledge slot");
	chk_sample_high: assert property (bit_rise && !start_det
		&& !stop_det && state_r != PSS_IDLE && state_r != PSS_IGNORE
		|=> rx_sh_r[0] == $past(sda_s_r))
		else $error("bit not sampled at clock rise");
	chk_wr_issue: assert property (byte_fall && !start_det
		&& !stop_det && state_r == PSS_WDATA |=>
		$changed(wr_tgl_r) && wr_data_lk_r == $past(rx_sh_r))
		else $error("write byte not issued");
	chk_ack_hold: assert property (!oe_n_r && cnt_r == PSS_CNT_ACK
		&& !scl_fall && !start_det && !stop_det |=> !oe_n_r)
		else $error("acknowledge released early");
endmodule

// File: testbench/pss_bus_master.sv
// Behavioural bus master driving the serial clock and data lines
`timescale 1ns/1ps
module pss_bus_master (
	// Timing reference
	input  wire logic clk_i,
	// Serial link, resolved data line in
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_oe_n_o
);
	initial begin
		scl_o      = 1'b1;
		sda_oe_n_o = 1'b1;
	end

	// Quarter period of 500 ns keeps each phase above three link clocks
	task automatic qtr();
		repeat (5) @(negedge clk_i);
	endtask

	// Also a repeated start when entered with the clock low
	task automatic start();
		sda_oe_n_o = 1'b1;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_oe_n_o = 1'b0;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask

	task automatic stop();
		sda_oe_n_o = 1'b0;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_oe_n_o = 1'b1;
		qtr();
	endtask

	// Data moves only while the clock is low; sampled at end of high
	task automatic bit_io(input logic b, output logic s);
		sda_oe_n_o = b;
		qtr();
		scl_o = 1'b1;
		qtr();
		s = sda_i;
		scl_o = 1'b0;
		qtr();
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack_n);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, ack_n);
	endtask

	task automatic rbyte(input logic ack_n, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(ack_n, s);
	endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the serial register slave
`timescale 1ns/1ps
module testbench;
	import pss_pkg::*;
	logic       clk_i, rst_i, link_clk_i, scl, sda_m_oe_n, sda_w;
	logic       sda_o, sda_oe_n_o, wr_valid_o, bus_busy_o;
	logic [7:0] wr_addr_o, wr_data_o, rd_addr_o, rd_data_i;
	logic [7:0] regs [256];
	int         n_errors, cmp_count;

	// Pull-up on the data line: anyone enabled pulls it low
	assign sda_w = sda_m_oe_n & (sda_oe_n_o | sda_o);
	assign rd_data_i = regs[rd_addr_o];

	always @(posedge clk_i) begin
		if (wr_valid_o === 1'b1) begin
			regs[wr_addr_o] <= wr_data_o;
		end
	end

	pss_serial_slave i_pss_serial_slave (.clk_i(clk_i), .rst_i(rst_i),
		.link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wr_valid_o(wr_valid_o),
		.wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
		.rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
		.bus_busy_o(bus_busy_o));
	pss_bus_master i_pss_bus_master (.clk_i(clk_i), .sda_i(sda_w),
		.scl_o(scl), .sda_oe_n_o(sda_m_oe_n));

	initial clk_i = 1'b0;
	always #50 clk_i = ~clk_i;
	initial begin
		link_clk_i = 1'b0;
		#17;
		forever #62.5 link_clk_i = ~link_clk_i;
	end

	function automatic logic [7:0] init_val(input logic [7:0] a);
		return a ^ 8'h5a;
	endfunction

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic send(input logic [7:0] d, input logic exp_n);
		logic a;
		i_pss_bus_master.wbyte(d, a);
		chk("ack", {7'h00, exp_n}, {7'h00, a});
	endtask

	task automatic set_ptr(input logic [7:0] p);
		i_pss_bus_master.start();
		send({PSS_SLAVE_ADDR, 1'b0}, 1'b0);
		send(p, 1'b0);
	endtask

	task automatic read_at(input logic [7:0] p);
		set_ptr(p);
		i_pss_bus_master.start();
		send({PSS_SLAVE_ADDR, 1'b1}, 1'b0);
	endtask

	task automatic finish_xfer();
		i_pss_bus_master.stop();
		repeat (12) @(negedge clk_i);
		chk("busy after stop", 8'h00, {7'h00, bus_busy_o});
	endtask

	task automatic t_write();
		set_ptr(8'h10);
		chk("busy in transfer", 8'h01, {7'h00, bus_busy_o});
		send(8'ha5, 1'b0);
		send(8'h3c, 1'b0);
		finish_xfer();
		chk("reg 10", 8'ha5, regs[8'h10]);
		chk("reg 11", 8'h3c, regs[8'h11]);
	endtask

	task automatic t_read();
		logic [7:0] d;
		read_at(8'h0f);
		chk("busy after sr", 8'h01, {7'h00, bus_busy_o});
		i_pss_bus_master.rbyte(1'b0, d);
		chk("rd 0f", init_val(8'h0f), d);
		i_pss_bus_master.rbyte(1'b0, d);
		chk("rd 10", 8'ha5, d);
		i_pss_bus_master.rbyte(1'b1, d);
		chk("rd 11", 8'h3c, d);
		finish_xfer();
	endtask

	task automatic t_foreign();
		i_pss_bus_master.start();
		send({7'h3c, 1'b0}, 1'b1);
		send(8'h30, 1'b1);
		send(8'h99, 1'b1);
		finish_xfer();
		chk("reg 30", init_val(8'h30), regs[8'h30]);
	endtask

	task automatic t_abort();
		logic       s;
		logic [7:0] d;
		set_ptr(8'h20);
		for (int i = 0; i < 4; i++) begin
			i_pss_bus_master.bit_io(1'b1, s);
		end
		finish_xfer();
		chk("reg 20", init_val(8'h20), regs[8'h20]);
		read_at(8'h20);
		i_pss_bus_master.rbyte(1'b1, d);
		chk("rd 20", init_val(8'h20), d);
		finish_xfer();
	endtask

	initial begin
		n_errors  = 0;
		cmp_count = 0;
		for (int i = 0; i < 256; i++) begin
			regs[i] = init_val(8'(i));
		end
		rst_i = 1'b1;
		repeat (6) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (10) @(negedge clk_i);
		t_write();
		t_read();
		t_foreign();
		t_abort();
		chk("data pin level", 8'h00, {7'h00, sda_o});
		end_sim();
	end

	// About 300 us of traffic expected; ten times that is a hang
	initial begin
		#3_000_000;
		n_errors++;
		end_sim();
	end
endmodule
